// ---- cso_map.svh ----
// cso_map.svh: address width, offsets, field positions and reset values for the stop reaction block
// assumes: included by bare name from the design, checker and bench modules
`ifndef CSO_MAP_SVH
`define CSO_MAP_SVH

`define CSO_ADDR_W 4
`define CSO_OFS_CFG 4'h0
`define CSO_OFS_PULSE 4'h1
`define CSO_OFS_START 4'h2
`define CSO_OFS_CMP 4'h3
`define CSO_OFS_STATUS 4'h4
`define CSO_OFS_DIAG 4'h5

`define CSO_CFG_REACT_LO 0
`define CSO_CFG_REACT_HI 1
`define CSO_CFG_SUBST0 2
`define CSO_CFG_SUBST1 3
`define CSO_CFG_WB_EN 4
`define CSO_CFG_ADD_EN 5
`define CSO_CFG_PULSE0 6
`define CSO_CFG_PULSE1 7
`define CSO_CFG_ENC_LO 8
`define CSO_CFG_ENC_HI 9
`define CSO_CFG_RST 32'h0000_0000

`define CSO_PULSE_RST 32'h0000_0064
`define CSO_START_RST 32'h0000_0000
`define CSO_CMP_RST 32'h0000_0010

`endif

// ---- cso_pkg.sv ----
// cso_pkg.sv: types of the stop reaction block
// assumes: nothing beyond the map header
`default_nettype none
package cso_pkg;
    typedef enum logic [1:0] {
        CSO_CONTINUE = 2'b00,
        CSO_SUBST = 2'b01,
        CSO_KEEP = 2'b10
    } cso_react_t;

    typedef enum logic [1:0] {
        CSO_ENC_PUSHPULL = 2'b00,
        CSO_ENC_RS422 = 2'b01,
        CSO_ENC_SSI = 2'b10,
        CSO_ENC_OTHER = 2'b11
    } cso_enc_t;

    typedef enum logic [1:0] {
        CSO_ST_RUN = 2'b00,
        CSO_ST_STOP = 2'b01,
        CSO_ST_RESTART = 2'b10
    } cso_state_t;
endpackage
`default_nettype wire

// ---- cso_plc_model.sv ----
// cso_plc_model.sv: supervising controller model, drives the run/stop level
// assumes: bench asks for run or stop through want_run; one clock
`timescale 1ns/1ns
`default_nettype none
module cso_plc_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic want_run,
    output logic ctrl_run
);
    // level moves only on an edge, so every stop-to-run is one clean step
    always_ff @(posedge clk_sys) begin
        if (rst)
            ctrl_run <= 1'b1;
        else
            ctrl_run <= want_run;
    end
endmodule // cso_plc_model
`default_nettype wire

// ---- cso_pulse.sv ----
// cso_pulse.sv: one switching output, level or timed pulse on comparison
// assumes: clk_sys domain; cmp_hit is a same-clock one-cycle pulse
`timescale 1ns/1ns
`default_nettype none
module cso_pulse #(
    parameter int CW = 32
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic clear,
    input wire logic pulse_mode,
    input wire logic cmp_level,
    input wire logic cmp_hit,
    input wire logic [CW-1:0] pulse_len,
    output logic level,
    output logic pulsing
);
    logic [CW-1:0] remain;

    // the pulse keeps timing regardless of the stop reaction
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            remain <= '0;
            pulsing <= 1'b0;
        end else if (ce) begin
            if (clear) begin
                remain <= '0;
                pulsing <= 1'b0;
            end else if (pulse_mode && cmp_hit && pulse_len != '0) begin
                remain <= pulse_len;
                pulsing <= 1'b1;
            end else if (remain > 1) begin
                remain <= remain - 1'b1;
            end else begin
                remain <= '0;
                pulsing <= 1'b0;
            end
        end
    end

    assign level = pulse_mode ? pulsing : cmp_level;
endmodule // cso_pulse
`default_nettype wire

// ---- cso_stop_react.sv ----
// cso_stop_react.sv: counter channel with reaction to controller stop and diagnostic gating
// assumes: controller run level and encoder/diag inputs are asynchronous pins; plain register port
//
// Function
// - each channel has its own reaction: continue, substitute value or keep last
// - continue: counter keeps counting and outputs keep switching during stop
// - substitute: configured substitute levels drive outputs until stop-to-run
// - keep last: outputs hold their stop-entry levels until stop-to-run
// - keep last: a timed pulse output active at stop still clears at expiry
// - after stop-to-run in substitute or keep, reload start value, resume outputs
// - separate substitute levels for first and second switching outputs
// - diagnostic interrupts only raised when their enables are set; default off
// - wire-break diagnostic for push-pull 24 V, RS422 and SSI encoders when enabled
// - RS422 and SSI also flag short-circuit and bad supply under that enable
// - other encoder types raise no wire-break diagnostic
// - separate enable gates diagnostics for other operating errors
`include "cso_map.svh"
`timescale 1ns/1ns
`default_nettype none
module cso_stop_react #(
    parameter int CW = 32
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic [`CSO_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic ctrl_run,
    input wire logic enc_count_up,
    input wire logic enc_count_dn,
    input wire logic enc_wire_break,
    input wire logic enc_short,
    input wire logic enc_supply_bad,
    input wire logic op_error,
    output logic first_switch_output,
    output logic second_switch_output,
    output logic diag_wb_irq,
    output logic diag_add_irq,
    output logic [CW-1:0] count_value
);
    logic [31:0] cfg;
    logic [CW-1:0] pulse_len;
    logic [CW-1:0] start_val;
    logic [CW-1:0] cmp_val;
    logic [7:0] pin_s;
    logic run_s;
    logic up_s;
    logic dn_s;
    logic wb_s;
    logic sh_s;
    logic sup_s;
    logic op_s;
    logic up_d;
    logic dn_d;
    logic run_d;
    logic stop_entry;
    logic run_entry;
    cso_pkg::cso_state_t state;
    cso_pkg::cso_state_t next_state;
    cso_pkg::cso_react_t react;
    cso_pkg::cso_enc_t enc;
    logic [1:0] held;
    logic [1:0] live;
    logic [1:0] pulsing;
    logic [1:0] pmode;
    logic [1:0] cmp_level;
    logic cmp_hit;
    logic frozen;
    logic [1:0] next_out;
    logic wb_cond;
    logic cmp_now;
    logic cmp_prev;
    logic up_edge;
    logic dn_edge;
    logic [1:0] subst_lvl;
    logic [1:0] kept;
    logic [7:0] status_word;
    logic [2:0] diag_word;

    // encoder kinds that carry line monitoring
    function automatic logic cso_enc_monitored(input cso_pkg::cso_enc_t e);
        cso_enc_monitored = (e == cso_pkg::CSO_ENC_PUSHPULL) || (e == cso_pkg::CSO_ENC_RS422) ||
                            (e == cso_pkg::CSO_ENC_SSI);
    endfunction

    function automatic logic cso_enc_diff(input cso_pkg::cso_enc_t e);
        cso_enc_diff = (e == cso_pkg::CSO_ENC_RS422) || (e == cso_pkg::CSO_ENC_SSI);
    endfunction

    function automatic logic cso_rise(input logic now_lvl, input logic was_lvl);
        cso_rise = now_lvl && !was_lvl;
    endfunction

    // all pin inputs cross here before any logic looks at them
    cso_sync #(
        .W(8)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .d({1'b0, op_error, enc_supply_bad, enc_short, enc_wire_break, enc_count_dn, enc_count_up, ctrl_run}),
        .q(pin_s)
    );
    assign run_s = pin_s[0];
    assign up_s = pin_s[1];
    assign dn_s = pin_s[2];
    assign wb_s = pin_s[3];
    assign sh_s = pin_s[4];
    assign sup_s = pin_s[5];
    assign op_s = pin_s[6];

    assign react = cso_pkg::cso_react_t'(cfg[`CSO_CFG_REACT_HI:`CSO_CFG_REACT_LO]);
    assign enc = cso_pkg::cso_enc_t'(cfg[`CSO_CFG_ENC_HI:`CSO_CFG_ENC_LO]);
    assign pmode = {cfg[`CSO_CFG_PULSE1], cfg[`CSO_CFG_PULSE0]};

    // register writes
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg <= `CSO_CFG_RST;
            pulse_len <= CW'(`CSO_PULSE_RST);
            start_val <= CW'(`CSO_START_RST);
            cmp_val <= CW'(`CSO_CMP_RST);
        end else if (ce && reg_wr) begin
            case (reg_addr)
                `CSO_OFS_CFG: begin
                    // bits above the used fields stay zero on read back
                    cfg <= {22'h0, reg_wdata[9:0]};
                end
                `CSO_OFS_PULSE: begin
                    pulse_len <= reg_wdata[CW-1:0];
                end
                `CSO_OFS_START: begin
                    start_val <= reg_wdata[CW-1:0];
                end
                `CSO_OFS_CMP: begin
                    cmp_val <= reg_wdata[CW-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // run level edges, one-cycle events in this clock
    // run_d starts low like the synchroniser, so release of reset fakes no stop
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            run_d <= 1'b0;
            up_d <= 1'b0;
            dn_d <= 1'b0;
        end else if (ce) begin
            run_d <= run_s;
            up_d <= up_s;
            dn_d <= dn_s;
        end
    end
    assign stop_entry = run_d && !run_s;
    assign run_entry = !run_d && run_s;

    // pins count on their synchronised rising edge only
    assign up_edge = cso_rise(up_s, up_d);
    assign dn_edge = cso_rise(dn_s, dn_d);

    // continue skips restart, so the counter keeps its value
    always_comb begin
        next_state = state;
        case (state)
            cso_pkg::CSO_ST_RUN: begin
                if (stop_entry) begin
                    next_state = cso_pkg::CSO_ST_STOP;
                end
            end
            cso_pkg::CSO_ST_STOP: begin
                if (run_entry) begin
                    next_state = (react == cso_pkg::CSO_CONTINUE) ? cso_pkg::CSO_ST_RUN : cso_pkg::CSO_ST_RESTART;
                end
            end
            cso_pkg::CSO_ST_RESTART: begin
                next_state = cso_pkg::CSO_ST_RUN;
            end
            default: begin
                next_state = cso_pkg::CSO_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= cso_pkg::CSO_ST_RUN;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // counter runs in stop too; only restart after substitute or keep reloads it
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count_value <= '0;
        end else if (ce) begin
            if (state == cso_pkg::CSO_ST_RESTART) begin
                count_value <= start_val;
            end else if (up_edge) begin
                count_value <= count_value + 1'b1;
            end else if (dn_edge) begin
                count_value <= count_value - 1'b1;
            end
        end
    end

    // comparison: level mode is high at or above the compare value
    assign cmp_now = (count_value >= cmp_val);
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cmp_prev <= 1'b0;
        end else if (ce) begin
            cmp_prev <= cmp_now;
        end
    end
    // one pulse per crossing, not one per cycle above the value
    assign cmp_hit = cso_rise(cmp_now, cmp_prev);

    // both outputs share the one compare value
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_out
            assign cmp_level[gi] = cmp_now;
            cso_pulse #(
                .CW(CW)
            ) u_pulse (
                .clk_sys(clk_sys),
                .rst(rst),
                .ce(ce),
                .clear(state == cso_pkg::CSO_ST_RESTART),
                .pulse_mode(pmode[gi]),
                .cmp_level(cmp_level[gi]),
                .cmp_hit(cmp_hit),
                .pulse_len(pulse_len),
                .level(live[gi]),
                .pulsing(pulsing[gi])
            );
        end
    endgenerate

    // a held pulse output drops once its own timer has run out
    assign kept = held & ~(pmode & ~pulsing);
    assign subst_lvl = {cfg[`CSO_CFG_SUBST1], cfg[`CSO_CFG_SUBST0]};

    // snapshot of the driven levels at stop detection
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            held <= 2'b00;
        end else if (ce) begin
            if (stop_entry && state == cso_pkg::CSO_ST_RUN) begin
                held <= {second_switch_output, first_switch_output};
            end else if (state == cso_pkg::CSO_ST_STOP) begin
                // a held pulse still ends when its timer runs out
                held <= kept;
            end
        end
    end

    // substitute and keep act only while stop lasts
    assign frozen = (state == cso_pkg::CSO_ST_STOP);
    always_comb begin
        next_out = live;
        if (frozen) begin
            case (react)
                cso_pkg::CSO_SUBST: begin
                    next_out = subst_lvl;
                end
                cso_pkg::CSO_KEEP: begin
                    next_out = kept;
                end
                default: begin
                    next_out = live;
                end
            endcase
        end
    end

    // registered so the pins never see a decode glitch
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            first_switch_output <= 1'b0;
            second_switch_output <= 1'b0;
        end else if (ce) begin
            first_switch_output <= next_out[0];
            second_switch_output <= next_out[1];
        end
    end

    // diagnostics: level outputs, held while the condition lasts
    assign wb_cond = cso_enc_monitored(enc) && (wb_s || (cso_enc_diff(enc) && (sh_s || sup_s)));
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            diag_wb_irq <= 1'b0;
            diag_add_irq <= 1'b0;
        end else if (ce) begin
            diag_wb_irq <= cfg[`CSO_CFG_WB_EN] && wb_cond;
            diag_add_irq <= cfg[`CSO_CFG_ADD_EN] && op_s;
        end
    end

    assign status_word = {held, first_switch_output, second_switch_output, run_s, 1'b0, state};
    assign diag_word = {op_s, wb_cond, diag_wb_irq};

    // read port: data in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (ce) begin
            reg_rdata <= 32'h0000_0000;
            if (reg_rd) begin
                case (reg_addr)
                    `CSO_OFS_CFG: begin
                        reg_rdata <= cfg;
                    end
                    `CSO_OFS_PULSE: begin
                        reg_rdata <= 32'(pulse_len);
                    end
                    `CSO_OFS_START: begin
                        reg_rdata <= 32'(start_val);
                    end
                    `CSO_OFS_CMP: begin
                        reg_rdata <= 32'(cmp_val);
                    end
                    `CSO_OFS_STATUS: begin
                        reg_rdata <= {24'h000000, status_word};
                    end
                    `CSO_OFS_DIAG: begin
                        reg_rdata <= {29'h0, diag_word};
                    end
                    default: begin
                        reg_rdata <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end
endmodule // cso_stop_react
`default_nettype wire

// ---- cso_stop_react_asserts.sv ----
// cso_stop_react_asserts.sv: port checker for the stop reaction block
// assumes: bound to cso_stop_react; ce held high while checked
`include "cso_map.svh"
`timescale 1ns/1ns
`default_nettype none
module cso_stop_react_asserts #(
    parameter int CW = 32
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic [`CSO_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic ctrl_run,
    input wire logic enc_count_up,
    input wire logic enc_count_dn,
    input wire logic enc_wire_break,
    input wire logic enc_short,
    input wire logic enc_supply_bad,
    input wire logic op_error,
    input wire logic first_switch_output,
    input wire logic second_switch_output,
    input wire logic diag_wb_irq,
    input wire logic diag_add_irq,
    input wire logic [CW-1:0] count_value
);
    // shadows of the setup, so no internal view is needed
    logic [31:0] cfg_sh;
    logic [31:0] start_sh;
    logic [3:0] cfg_age;
    logic [3:0] stop_cnt;
    logic [3:0] enc_idle;
    logic wb_cause;
    assign wb_cause = enc_wire_break | enc_short | enc_supply_bad;
    always_ff @(posedge clk_sys) begin
        if (rst)
            cfg_sh <= `CSO_CFG_RST;
        else if (ce && reg_wr && reg_addr == `CSO_OFS_CFG)
            cfg_sh <= reg_wdata;
    end
    always_ff @(posedge clk_sys) begin
        if (rst)
            start_sh <= `CSO_START_RST;
        else if (ce && reg_wr && reg_addr == `CSO_OFS_START)
            start_sh <= reg_wdata;
    end
    // ages saturate: checks wait until setup and pins have settled
    always_ff @(posedge clk_sys) begin
        if (rst || (ce && reg_wr && reg_addr == `CSO_OFS_CFG))
            cfg_age <= 4'h0;
        else if (cfg_age != 4'hF)
            cfg_age <= cfg_age + 4'h1;
    end
    always_ff @(posedge clk_sys) begin
        if (rst || ctrl_run)
            stop_cnt <= 4'h0;
        else if (stop_cnt != 4'hF)
            stop_cnt <= stop_cnt + 4'h1;
    end
    always_ff @(posedge clk_sys) begin
        if (rst || enc_count_up || enc_count_dn)
            enc_idle <= 4'h0;
        else if (enc_idle != 4'hF)
            enc_idle <= enc_idle + 4'h1;
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    a_reset_quiet: assert property ($past(rst) |-> !diag_wb_irq && !diag_add_irq && count_value == '0)
        else $error("outputs not quiet after reset");
    a_wb_cause: assert property (diag_wb_irq |-> $past(wb_cause, 2) || $past(wb_cause, 3) || $past(wb_cause, 4))
        else $error("wire-break interrupt without cause");
    a_add_cause: assert property (diag_add_irq |-> $past(op_error, 2) || $past(op_error, 3) || $past(op_error, 4))
        else $error("additional interrupt without cause");
    a_irq_enable: assert property ((!diag_wb_irq || cfg_sh[4] || $past(cfg_sh[4]))
        && (!diag_add_irq || cfg_sh[5] || $past(cfg_sh[5]))) else $error("interrupt while disabled");
    a_other_enc: assert property (diag_wb_irq |-> cfg_sh[9:8] != 2'b11 || $past(cfg_sh[9:8]) != 2'b11)
        else $error("wire-break interrupt for other encoder");
    a_subst_hold: assert property (stop_cnt >= 8 && cfg_age >= 8 && cfg_sh[1:0] == 2'b01 |->
        first_switch_output == cfg_sh[2] && second_switch_output == cfg_sh[3]) else $error("substitute not shown");
    a_keep_hold: assert property (stop_cnt >= 8 && cfg_age >= 8 && cfg_sh[1:0] == 2'b10 |->
        (cfg_sh[6] || $stable(first_switch_output)) && (cfg_sh[7] || $stable(second_switch_output)))
        else $error("kept output moved");
    a_restart_load: assert property ($rose(ctrl_run) && stop_cnt >= 8 && cfg_sh[1:0] != 2'b00
        |-> ##[1:8] count_value == start_sh[CW-1:0]) else $error("start value not loaded");
    a_continue_count: assert property ($rose(ctrl_run) && stop_cnt >= 8 && cfg_sh[1:0] == 2'b00
        && enc_idle >= 8 |-> ##1 $stable(count_value) [*6]) else $error("counter moved on resume");
    c_subst: cover property (stop_cnt == 8 && cfg_sh[1:0] == 2'b01);
    c_keep: cover property (stop_cnt == 8 && cfg_sh[1:0] == 2'b10);
    c_resume: cover property ($rose(ctrl_run) && stop_cnt >= 8);
endmodule // cso_stop_react_asserts
bind cso_stop_react cso_stop_react_asserts #(.CW(CW)) cso_chk_u (.clk_sys, .rst, .ce, .reg_addr, .reg_wdata,
    .reg_wr, .ctrl_run, .enc_count_up, .enc_count_dn, .enc_wire_break, .enc_short, .enc_supply_bad, .op_error,
    .first_switch_output, .second_switch_output, .diag_wb_irq, .diag_add_irq, .count_value);
`default_nettype wire

// ---- cso_stop_react_bench.sv ----
// cso_stop_react_bench.sv: self-checking bench for the stop reaction block
// assumes: cso_plc_model drives the run level; ce held high
`include "cso_map.svh"
`timescale 1ns/1ns
`default_nettype none
module cso_stop_react_bench;
    logic clk_sys, rst, reg_wr, reg_rd, want_run, ctrl_run;
    logic up, dn, wb, sh, sup, op, first, second, wb_irq, add_irq;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, count_value;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;
    cso_plc_model plc_u (.clk_sys, .rst, .want_run, .ctrl_run);
    cso_stop_react dut_u (.clk_sys, .rst, .ce(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .ctrl_run, .enc_count_up(up), .enc_count_dn(dn), .enc_wire_break(wb), .enc_short(sh),
        .enc_supply_bad(sup), .op_error(op), .first_switch_output(first), .second_switch_output(second),
        .diag_wb_irq(wb_irq), .diag_add_irq(add_irq), .count_value);
    task automatic complete_run();
        if (errors == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    // pins are synchronised, so each level is held three cycles
    task automatic count_edges(input int n, input logic dir_up);
        repeat (n) begin
            @(posedge clk_sys);
            up <= dir_up;
            dn <= !dir_up;
            repeat (3) @(posedge clk_sys);
            up <= 1'b0;
            dn <= 1'b0;
            repeat (2) @(posedge clk_sys);
        end
    endtask
    task automatic run_level(input logic r);
        @(posedge clk_sys);
        want_run <= r;
        settle(8);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            complete_run();
        end
    end
    initial begin
        {rst, reg_wr, reg_rd, want_run} = 4'b1001;
        {up, dn, wb, sh, sup, op} = 6'h0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        wb <= 1'b1;
        op <= 1'b1;
        rd_chk(`CSO_OFS_CFG, `CSO_CFG_RST);
        rd_chk(`CSO_OFS_PULSE, `CSO_PULSE_RST);
        rd_chk(`CSO_OFS_CMP, `CSO_CMP_RST);
        rd_chk(`CSO_OFS_START, `CSO_START_RST);
        wr(4'hF, 32'hFFFF_FFFF);
        rd_chk(4'hF, 32'h0);
        rd_chk(`CSO_OFS_CFG, `CSO_CFG_RST);
        chk({wb_irq, add_irq}, 2'b00);
        @(posedge clk_sys);
        wb <= 1'b0;
        op <= 1'b0;
        wr(`CSO_OFS_START, 32'h5);
        wr(`CSO_OFS_CMP, 32'h2);
        wr(`CSO_OFS_CFG, 32'h9);
        count_edges(3, 1'b1);
        settle(6);
        chk(count_value, 32'h3);
        chk({first, second}, 2'b11);
        run_level(1'b0);
        chk({first, second}, 2'b01);
        rd_chk(`CSO_OFS_STATUS, 32'hD1);
        run_level(1'b1);
        chk(count_value, 32'h5);
        chk({first, second}, 2'b11);
        wr(`CSO_OFS_CMP, 32'h4);
        wr(`CSO_OFS_CFG, 32'h2);
        run_level(1'b0);
        count_edges(3, 1'b0);
        settle(6);
        chk({first, second}, 2'b11);
        run_level(1'b1);
        chk(count_value, 32'h5);
        wr(`CSO_OFS_CMP, 32'h7);
        wr(`CSO_OFS_CFG, 32'h0);
        run_level(1'b0);
        count_edges(2, 1'b1);
        settle(10);
        chk(count_value, 32'h7);
        chk({first, second}, 2'b11);
        run_level(1'b1);
        chk(count_value, 32'h7);
        // pulse of 20 cycles must outlive stop detection
        wr(`CSO_OFS_PULSE, 32'h14);
        wr(`CSO_OFS_CMP, 32'h8);
        wr(`CSO_OFS_CFG, 32'h42);
        count_edges(1, 1'b1);
        run_level(1'b0);
        chk({first, second}, 2'b11);
        settle(20);
        chk({first, second}, 2'b01);
        run_level(1'b1);
        @(posedge clk_sys);
        wb <= 1'b1;
        for (int e = 0; e < 4; e++) begin
            wr(`CSO_OFS_CFG, 32'h10 | (32'(e) << 8));
            settle(5);
            chk(wb_irq, e != 3);
        end
        @(posedge clk_sys);
        wb <= 1'b0;
        sh <= 1'b1;
        wr(`CSO_OFS_CFG, 32'h110);
        settle(5);
        chk(wb_irq, 1'b1);
        @(posedge clk_sys);
        sh <= 1'b0;
        sup <= 1'b1;
        wr(`CSO_OFS_CFG, 32'h210);
        settle(5);
        chk(wb_irq, 1'b1);
        rd_chk(`CSO_OFS_DIAG, 32'h3);
        wr(`CSO_OFS_CFG, 32'h200);
        settle(5);
        chk(wb_irq, 1'b0);
        @(posedge clk_sys);
        sup <= 1'b0;
        op <= 1'b1;
        wr(`CSO_OFS_CFG, 32'h20);
        settle(5);
        chk(add_irq, 1'b1);
        wr(`CSO_OFS_CFG, 32'h0);
        settle(5);
        chk(add_irq, 1'b0);
        complete_run();
    end
endmodule // cso_stop_react_bench
`default_nettype wire

// ---- cso_sync.sv ----
// cso_sync.sv: two flip-flop synchroniser for a vector of pin levels
// assumes: clk_sys domain, synchronous active high reset
`timescale 1ns/1ns
`default_nettype none
module cso_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta <= '0;
            q <= '0;
        end else if (ce) begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // cso_sync
`default_nettype wire
